/* File: inc/fsr_pkg.sv */
package fsr_pkg;

    // register port map, word offsets on a 4-bit address
    localparam logic [3:0] ADDR_STATE = 4'h0;
    localparam logic [3:0] ADDR_CLASS = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;

    // state word field positions
    localparam int POS_BUSY = 15;
    localparam int POS_COND_FLAG_THREE = 14;
    localparam int POS_TOP_HI = 13;
    localparam int POS_TOP_LO = 11;
    localparam int POS_COND_FLAG_TWO = 10;
    localparam int POS_COND_FLAG_ONE = 9;
    localparam int POS_COND_FLAG_ZERO = 8;
    localparam int POS_ERROR_SUMMARY = 7;
    localparam int POS_STACK_FAULT_FLAG = 6;
    localparam int POS_FLAG_HI = 5;
    localparam int POS_IE = 0;

    // control word: exception masks in bits 5..0
    localparam int POS_MASK_HI = 5;

    // reset values
    localparam logic [2:0] TOP_RESET = 3'h0;
    localparam logic [3:0] CC_RESET = 4'h0;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [15:0] CTRL_RESET = 16'h003F;
    localparam logic [15:0] CLASS_RESET = 16'hFFFF;

    // register classification codes
    localparam logic [1:0] TAG_VALID = 2'h0;
    localparam logic [1:0] TAG_ZERO = 2'h1;
    localparam logic [1:0] TAG_SPECIAL = 2'h2;
    localparam logic [1:0] TAG_EMPTY = 2'h3;

    // exponent biases of normalized values
    localparam logic [14:0] BIAS_SGL = 15'h007F;
    localparam logic [14:0] BIAS_DBL = 15'h03FF;
    localparam logic [14:0] BIAS_EXT = 15'h3FFF;
    localparam logic [14:0] EXP_EXT_MAX = 15'h7FFF;
    localparam logic [7:0] EXP_SGL_MAX = 8'hFF;
    localparam logic [10:0] EXP_DBL_MAX = 11'h7FF;

    // packed decimal: bits 78..72 carry no meaning
    localparam int BCD_PAD_HI = 78;
    localparam int BCD_PAD_LO = 72;

    typedef enum logic [1:0] {FMT_EXT, FMT_DBL, FMT_SGL, FMT_BCD} fsr_fmt_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_PUSH,
        OP_POP,
        OP_WRITE,
        OP_READ,
        OP_FREE
    } fsr_cmd_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } fsr_reg_req_t;

    typedef struct packed {
        fsr_cmd_t cmd;
        logic [2:0] rel;
        fsr_fmt_t fmt;
        logic [79:0] data;
        logic cc_we;
        logic [3:0] cc;
        logic [5:0] exc;
    } fsr_op_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [1:0] tag;
        logic [79:0] data;
    } fsr_result_t;

endpackage

/* File: design/fsr_core.sv */
`timescale 1ns/1ps

// Overview of operation
// RL1: normalized exponents use bias 127 single, 1023 double, 16383 extended.
// RL2: meaningless packed decimal bits ignored on load, zeroed on store.
// RL3: integer bit explicit in extended, implicit in single and double.
// RL4: push decrements stack head then writes the new head register; a state word write in the same cycle sets the head instead.
// RL5: pop delivers the head register then increments stack head; a state word write in the same cycle sets the head instead.
// RL6: implicit operations act on the register at the stack head.
// RL7: explicit register numbers are offsets from the stack head.
// RL8: class word has a two-bit field per data register.
// RL9: class fields indexed by physical register, not stack-relative.
// RL10: class codes: 00 valid, 01 zero, 10 special values.
// RL11: class 11 means empty; reset empties every register.
// RL12: state bit 15 mirrors error summary bit 7, not the busy pin.
// RL13: state bits 13..11 hold the physical stack head index.
// RL14: arithmetic updates the four condition flags from its outcome; a state word write in the same cycle sets them instead, except flag one on a stack fault.
// RL15: error summary set when an unmasked flag is set; drives error output.
// RL16: on stack fault, flag one is 1 for overflow, 0 for underflow.
// RL17: state bits 5..0 are six exception flags set on detection.
// RL18: restoring the state word recomputes summary; error asserts at once.
// RL19: state word readable; options come from the loaded control word.
// RL20: stack head index wraps modulo eight.
// RL21: unmasked exception sets flag, summary and error output.
module fsr_core (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // software register port
    input wire fsr_pkg::fsr_reg_req_t reg_req_in,
    output logic [15:0] reg_rdata_out,
    // datapath operation port
    input wire fsr_pkg::fsr_op_t op_in,
    output fsr_pkg::fsr_result_t result_out,
    // error to host
    output logic error_out
);

    logic [79:0] regs [8];
    logic [2:0] top;
    logic [15:0] class_word;
    logic [3:0] cc;
    logic stack_fault_flag;
    logic [5:0] flags;
    logic [15:0] ctrl;
    logic error_summary;
    logic [15:0] state_word;
    logic [2:0] idx;
    logic [2:0] push_idx;
    logic push_fault;
    logic pop_fault;
    logic [79:0] load_val;
    logic wr_state;
    logic wr_class;
    logic wr_ctrl;
    logic [5:0] next_flags;

    function automatic logic [2:0] phys_index(input logic [2:0] head, input logic [2:0] rel);
        phys_index = head + rel; // [RL7] [RL20]
    endfunction

    function automatic logic [1:0] tag_of(input logic [15:0] word, input logic [2:0] n);
        tag_of = word[2*n +: 2]; // [RL9]
    endfunction

    // classify an extended value
    function automatic logic [1:0] classify(input logic [79:0] v);
        logic [14:0] e;
        logic [63:0] m;
        e = v[78:64];
        m = v[63:0];
        if (e == 15'h0000 && m == 64'h0) begin
            classify = fsr_pkg::TAG_ZERO; // [RL10]
        end else if (e == fsr_pkg::EXP_EXT_MAX || e == 15'h0000 || !m[63]) begin
            classify = fsr_pkg::TAG_SPECIAL; // [RL10]
        end else begin
            classify = fsr_pkg::TAG_VALID; // [RL10]
        end
    endfunction

    // memory format to internal extended
    function automatic logic [79:0] load_conv(input fsr_pkg::fsr_fmt_t fmt,
                                              input logic [79:0] d);
        logic [14:0] e;
        load_conv = d;
        e = 15'h0000;
        unique case (fmt)
            fsr_pkg::FMT_EXT: begin
                load_conv = d; // [RL3]
            end
            fsr_pkg::FMT_SGL: begin
                if (d[30:23] == 8'h00) begin
                    e = 15'h0000;
                end else if (d[30:23] == fsr_pkg::EXP_SGL_MAX) begin
                    e = fsr_pkg::EXP_EXT_MAX;
                end else begin
                    e = 15'(d[30:23]) - fsr_pkg::BIAS_SGL + fsr_pkg::BIAS_EXT; // [RL1]
                end
                // implicit integer bit made explicit
                load_conv = {d[31], e, (d[30:23] != 8'h00), d[22:0], 40'h0}; // [RL3]
            end
            fsr_pkg::FMT_DBL: begin
                if (d[62:52] == 11'h000) begin
                    e = 15'h0000;
                end else if (d[62:52] == fsr_pkg::EXP_DBL_MAX) begin
                    e = fsr_pkg::EXP_EXT_MAX;
                end else begin
                    e = 15'(d[62:52]) - fsr_pkg::BIAS_DBL + fsr_pkg::BIAS_EXT; // [RL1]
                end
                load_conv = {d[63], e, (d[62:52] != 11'h000), d[51:0], 11'h0}; // [RL3]
            end
            fsr_pkg::FMT_BCD: begin
                load_conv[fsr_pkg::BCD_PAD_HI:fsr_pkg::BCD_PAD_LO] = 7'h00; // [RL2]
            end
        endcase
    endfunction

    // internal extended to memory format, truncating the fraction
    function automatic logic [79:0] store_conv(input fsr_pkg::fsr_fmt_t fmt,
                                               input logic [79:0] v);
        logic [14:0] e;
        logic [14:0] r;
        e = v[78:64];
        store_conv = v;
        r = 15'h0000;
        unique case (fmt)
            fsr_pkg::FMT_EXT: begin
                store_conv = v; // [RL3]
            end
            fsr_pkg::FMT_SGL: begin
                if (e == 15'h0000) begin
                    r = 15'h0000;
                end else if (e == fsr_pkg::EXP_EXT_MAX) begin
                    r = 15'(fsr_pkg::EXP_SGL_MAX);
                end else begin
                    r = e - fsr_pkg::BIAS_EXT + fsr_pkg::BIAS_SGL; // [RL1]
                end
                // integer bit dropped: implicit in short form
                store_conv = {48'h0, v[79], r[7:0], v[62:40]}; // [RL3]
            end
            fsr_pkg::FMT_DBL: begin
                if (e == 15'h0000) begin
                    r = 15'h0000;
                end else if (e == fsr_pkg::EXP_EXT_MAX) begin
                    r = 15'(fsr_pkg::EXP_DBL_MAX);
                end else begin
                    r = e - fsr_pkg::BIAS_EXT + fsr_pkg::BIAS_DBL; // [RL1]
                end
                store_conv = {16'h0, v[79], r[10:0], v[62:11]}; // [RL3]
            end
            fsr_pkg::FMT_BCD: begin
                store_conv[fsr_pkg::BCD_PAD_HI:fsr_pkg::BCD_PAD_LO] = 7'h00; // [RL2]
            end
        endcase
    endfunction

    assign wr_state = reg_req_in.wr && reg_req_in.addr == fsr_pkg::ADDR_STATE;
    assign wr_class = reg_req_in.wr && reg_req_in.addr == fsr_pkg::ADDR_CLASS;
    assign wr_ctrl = reg_req_in.wr && reg_req_in.addr == fsr_pkg::ADDR_CTRL;

    assign idx = phys_index(top, op_in.rel); // [RL6] [RL7]
    assign push_idx = top - 3'h1; // [RL4] [RL20]
    assign push_fault = op_in.cmd == fsr_pkg::OP_PUSH
        && tag_of(class_word, push_idx) != fsr_pkg::TAG_EMPTY;
    assign pop_fault = op_in.cmd == fsr_pkg::OP_POP
        && tag_of(class_word, top) == fsr_pkg::TAG_EMPTY;
    assign load_val = load_conv(op_in.fmt, op_in.data);

    // summary recomputed from flags and masks, never stored
    assign error_summary = |(flags & ~ctrl[fsr_pkg::POS_MASK_HI:0]); // [RL15] [RL18] [RL21]
    assign error_out = error_summary; // [RL15] [RL21]

    always_comb begin
        state_word = 16'h0000;
        state_word[fsr_pkg::POS_BUSY] = error_summary; // [RL12]
        state_word[fsr_pkg::POS_COND_FLAG_THREE] = cc[3];
        state_word[fsr_pkg::POS_TOP_HI:fsr_pkg::POS_TOP_LO] = top; // [RL13]
        state_word[fsr_pkg::POS_COND_FLAG_TWO] = cc[2];
        state_word[fsr_pkg::POS_COND_FLAG_ONE] = cc[1];
        state_word[fsr_pkg::POS_COND_FLAG_ZERO] = cc[0];
        state_word[fsr_pkg::POS_ERROR_SUMMARY] = error_summary; // [RL15]
        state_word[fsr_pkg::POS_STACK_FAULT_FLAG] = stack_fault_flag;
        state_word[fsr_pkg::POS_FLAG_HI:0] = flags; // [RL17]
    end

    // stack head
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            top <= fsr_pkg::TOP_RESET;
        end else if (wr_state) begin
            top <= reg_req_in.wdata[fsr_pkg::POS_TOP_HI:fsr_pkg::POS_TOP_LO]; // [RL18]
        end else if (op_in.cmd == fsr_pkg::OP_PUSH && !push_fault) begin
            top <= push_idx; // [RL4] [RL20]
        end else if (op_in.cmd == fsr_pkg::OP_POP && !pop_fault) begin
            top <= top + 3'h1; // [RL5] [RL20]
        end
    end

    // data registers
    always_ff @(posedge clk_in) begin
        if (op_in.cmd == fsr_pkg::OP_PUSH && !push_fault) begin
            regs[push_idx] <= load_val; // [RL4]
        end else if (op_in.cmd == fsr_pkg::OP_WRITE) begin
            regs[idx] <= load_val; // [RL6] [RL7]
        end
    end

    // class word
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            class_word <= fsr_pkg::CLASS_RESET; // [RL11]
        end else if (wr_class) begin
            class_word <= reg_req_in.wdata;
        end else begin
            unique case (op_in.cmd)
                fsr_pkg::OP_PUSH: begin
                    if (!push_fault) begin
                        class_word[2*push_idx +: 2] <= classify(load_val); // [RL8] [RL9]
                    end
                end
                fsr_pkg::OP_WRITE: begin
                    class_word[2*idx +: 2] <= classify(load_val); // [RL9] [RL10]
                end
                fsr_pkg::OP_POP: begin
                    class_word[2*top +: 2] <= fsr_pkg::TAG_EMPTY; // [RL11]
                end
                fsr_pkg::OP_FREE: begin
                    class_word[2*idx +: 2] <= fsr_pkg::TAG_EMPTY; // [RL11]
                end
                fsr_pkg::OP_NONE, fsr_pkg::OP_READ: begin
                end
                default: begin
                end
            endcase
        end
    end

    // condition flags and stack fault
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cc <= fsr_pkg::CC_RESET;
            stack_fault_flag <= 1'b0;
        end else if (wr_state) begin
            cc <= {reg_req_in.wdata[fsr_pkg::POS_COND_FLAG_THREE],
                   reg_req_in.wdata[fsr_pkg::POS_COND_FLAG_TWO],
                   reg_req_in.wdata[fsr_pkg::POS_COND_FLAG_ONE],
                   reg_req_in.wdata[fsr_pkg::POS_COND_FLAG_ZERO]};
            stack_fault_flag <= reg_req_in.wdata[fsr_pkg::POS_STACK_FAULT_FLAG]
                || push_fault || pop_fault;
            // a fault in the restore cycle still reports its direction
            if (push_fault || pop_fault) begin
                cc[1] <= push_fault; // [RL16]
            end
        end else begin
            if (op_in.cc_we) begin
                cc <= op_in.cc; // [RL14]
            end
            if (push_fault || pop_fault) begin
                stack_fault_flag <= 1'b1;
                cc[1] <= push_fault; // [RL16]
            end
        end
    end

    // exception flags: hardware set wins over a software write
    always_comb begin
        next_flags = wr_state ? reg_req_in.wdata[fsr_pkg::POS_FLAG_HI:0] : flags; // [RL18]
        next_flags = next_flags | op_in.exc; // [RL17] [RL21]
        if (push_fault || pop_fault) begin
            next_flags[fsr_pkg::POS_IE] = 1'b1; // [RL16] [RL17]
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags <= fsr_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // control word
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl <= fsr_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= reg_req_in.wdata; // [RL19]
        end
    end

    // operation results
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_out <= '0;
        end else begin
            result_out.valid <= op_in.cmd == fsr_pkg::OP_POP || op_in.cmd == fsr_pkg::OP_READ;
            result_out.fault <= pop_fault;
            if (op_in.cmd == fsr_pkg::OP_POP) begin
                result_out.data <= store_conv(op_in.fmt, regs[top]); // [RL5] [RL6]
                result_out.tag <= tag_of(class_word, top);
            end else if (op_in.cmd == fsr_pkg::OP_READ) begin
                result_out.data <= store_conv(op_in.fmt, regs[idx]); // [RL7]
                result_out.tag <= tag_of(class_word, idx);
            end
        end
    end

    // register read port
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                fsr_pkg::ADDR_STATE: reg_rdata_out <= state_word; // [RL19]
                fsr_pkg::ADDR_CLASS: reg_rdata_out <= class_word; // [RL8]
                fsr_pkg::ADDR_CTRL: reg_rdata_out <= ctrl;
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule

/* File: dv/fsr_core_properties.sv */
`timescale 1ns/1ps
module fsr_core_properties (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire fsr_pkg::fsr_reg_req_t reg_req_in,
    input wire logic [15:0] reg_rdata_out,
    input wire fsr_pkg::fsr_op_t op_in,
    input wire fsr_pkg::fsr_result_t result_out,
    input wire logic error_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // quiet state read: no operation can move the flags at the same edge
    sequence s_rd_state;
        reg_req_in.rd && reg_req_in.addr == fsr_pkg::ADDR_STATE
            && op_in.cmd == fsr_pkg::OP_NONE && op_in.exc == 6'h00;
    endsequence
    sequence s_fetch;
        op_in.cmd == fsr_pkg::OP_POP || op_in.cmd == fsr_pkg::OP_READ;
    endsequence
    property p_rdata_idle;
        !reg_req_in.rd |=> reg_rdata_out == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_mirror;
        s_rd_state |=> reg_rdata_out[15] == reg_rdata_out[7];
    endproperty
    a_mirror: assert property (p_mirror) else $error("bit 15 differs from bit 7");
    property p_es_pin;
        s_rd_state |=> reg_rdata_out[7] == error_out;
    endproperty
    a_es_pin: assert property (p_es_pin) else $error("error output differs from summary");
    property p_answer;
        s_fetch |=> result_out.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no result after fetch");
    property p_pulse;
        result_out.valid |-> $past(op_in.cmd) inside {fsr_pkg::OP_POP, fsr_pkg::OP_READ};
    endproperty
    a_pulse: assert property (p_pulse) else $error("result without fetch");
    property p_fault_tag;
        result_out.valid && result_out.fault |-> result_out.tag == fsr_pkg::TAG_EMPTY;
    endproperty
    a_fault_tag: assert property (p_fault_tag) else $error("fault on non-empty register");
    property p_pop_fault;
        op_in.cmd == fsr_pkg::OP_POP |=> result_out.fault == (result_out.tag == fsr_pkg::TAG_EMPTY);
    endproperty
    a_pop_fault: assert property (p_pop_fault) else $error("pop fault does not match tag");
    property p_hold;
        !(op_in.cmd inside {fsr_pkg::OP_POP, fsr_pkg::OP_READ}) |=> $stable(result_out.data);
    endproperty
    a_hold: assert property (p_hold) else $error("result data moved without fetch");
    property p_err_cause;
        $rose(error_out) |-> $past(reg_req_in.wr) || $past(op_in.exc) != 6'h00
            || $past(op_in.cmd) inside {fsr_pkg::OP_PUSH, fsr_pkg::OP_POP};
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error output rose without cause");
endmodule

bind fsr_core fsr_core_properties i_props (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .op_in(op_in),
    .result_out(result_out), .error_out(error_out));

/* File: dv/fsr_host_model.sv */
`timescale 1ns/1ps
module fsr_host_model (
    // clock
    input wire logic clk_in,
    // instruction stream to the block
    output fsr_pkg::fsr_op_t op_out
);
    initial begin
        op_out = '0;
    end
    // one-cycle request; operand lines show junk once released
    task automatic issue(input fsr_pkg::fsr_op_t op);
        fsr_pkg::fsr_op_t idle;
        idle = op;
        idle.cmd = fsr_pkg::OP_NONE;
        idle.cc_we = 1'b0;
        idle.exc = 6'h00;
        idle.data = ~op.data;
        @(posedge clk_in);
        op_out <= op;
        @(posedge clk_in);
        op_out <= idle;
    endtask
endmodule

/* File: dv/fsr_core_tb.sv */
`timescale 1ns/1ps
module fsr_core_tb;
    typedef struct packed {logic [83:0] v; logic [83:0] m;} fsr_exp_t;
    logic clk_in;
    logic resetn_in;
    fsr_pkg::fsr_reg_req_t reg_req_in;
    logic [15:0] reg_rdata_out;
    fsr_pkg::fsr_op_t op_in;
    fsr_pkg::fsr_result_t result_out;
    logic error_out;
    logic rd_seen;
    int failures;
    int n_compared;
    int cycles;
    integer seed;
    fsr_exp_t q_reg[$];
    fsr_exp_t q_op[$];
    fsr_exp_t x_reg;
    fsr_exp_t x_op;
    logic [79:0] vals[8];
    logic [79:0] bcd;
    logic [15:0] cls;
    logic [7:0] e;
    logic [22:0] f;

    fsr_core i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_req_in(reg_req_in),
        .reg_rdata_out(reg_rdata_out), .op_in(op_in), .result_out(result_out),
        .error_out(error_out));
    fsr_host_model i_host (.clk_in(clk_in), .op_out(op_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [83:0] exp, input logic [83:0] seen,
                         input logic [83:0] m);
        n_compared++;
        if ((seen & m) !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen & m);
        end
    endtask

    task automatic summarize;
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        reg_req_in <= '0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m);
        @(posedge clk_in);
        reg_req_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        q_reg.push_back('{v: {68'h0, x & m}, m: {68'h0, m}});
        @(posedge clk_in);
        reg_req_in <= '0;
    endtask

    task automatic op(input fsr_pkg::fsr_cmd_t c, input logic [2:0] r, input fsr_pkg::fsr_fmt_t t,
                      input logic [79:0] d, input logic [83:0] x, input logic [83:0] m);
        if (c == fsr_pkg::OP_POP || c == fsr_pkg::OP_READ) begin
            q_op.push_back('{v: x & m, m: m});
        end
        i_host.issue('{cmd: c, rel: r, fmt: t, data: d, cc_we: 1'b0, cc: 4'h0, exc: 6'h00});
    endtask

    task automatic chk_err(input logic x);
        #1;
        check("error_out", {83'h0, x}, {83'h0, error_out}, 84'h1);
    endtask

    always @(posedge clk_in) begin
        rd_seen <= reg_req_in.rd;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end

    // scoreboard: oldest note against each answer
    always @(negedge clk_in) begin
        if (rd_seen === 1'b1) begin
            x_reg = '{v: '1, m: '0};
            if (q_reg.size() > 0) x_reg = q_reg.pop_front();
            check("reg_rdata_out", x_reg.v, {68'h0, reg_rdata_out}, x_reg.m);
        end
        if (result_out.valid === 1'b1) begin
            x_op = '{v: '1, m: '0};
            if (q_op.size() > 0) x_op = q_op.pop_front();
            check("result_out", x_op.v, result_out, x_op.m);
        end
    end

    initial begin
        seed = 32'h2a77e55b;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        rd_seen = 1'b0;
        reg_req_in = '0;
        resetn_in = 1'b0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        reg_rd(fsr_pkg::ADDR_CLASS, 16'hFFFF, 16'hFFFF);
        reg_rd(fsr_pkg::ADDR_STATE, 16'h0000, 16'hFFFF);
        reg_rd(fsr_pkg::ADDR_CTRL, 16'h003F, 16'hFFFF);
        reg_rd(4'h5, 16'h0000, 16'hFFFF);
        // eight pushes of valid, zero and special values, head wraps 0 to 7 down to 0
        for (int k = 0; k < 8; k++) begin
            vals[k] = {1'b0, 15'h3FFF + 15'(k), 1'b1, 63'($random(seed))};
            if (k % 3 == 1) vals[k] = 80'h0;
            if (k % 3 == 2) vals[k][78:64] = 15'h7FFF;
            cls[2 * (7 - k) +: 2] = 2'(k % 3);
            op(fsr_pkg::OP_PUSH, 3'h0, fsr_pkg::FMT_EXT, vals[k], '0, '0);
            reg_rd(fsr_pkg::ADDR_STATE, {2'b00, 3'(7 - k), 11'h000}, 16'h3800);
        end
        reg_rd(fsr_pkg::ADDR_CLASS, cls, 16'hFFFF);
        op(fsr_pkg::OP_PUSH, 3'h0, fsr_pkg::FMT_EXT, vals[0], '0, '0);
        reg_rd(fsr_pkg::ADDR_STATE, 16'h0241, 16'hFFFF);
        op(fsr_pkg::OP_POP, 3'h0, fsr_pkg::FMT_EXT, '0, {2'b10, 2'b01, vals[7]}, '1);
        for (int r = 0; r < 7; r++) begin
            op(fsr_pkg::OP_READ, 3'(r), fsr_pkg::FMT_EXT, '0,
               {2'b10, 2'((6 - r) % 3), vals[6 - r]}, '1);
        end
        op(fsr_pkg::OP_READ, 3'h7, fsr_pkg::FMT_EXT, '0, {4'hB, 80'h0}, {4'hF, 80'h0});
        for (int r = 1; r < 8; r++) begin
            op(fsr_pkg::OP_POP, 3'h0, fsr_pkg::FMT_EXT, '0,
               {2'b10, 2'((7 - r) % 3), vals[7 - r]}, '1);
        end
        reg_wr(fsr_pkg::ADDR_STATE, 16'h0000);
        op(fsr_pkg::OP_POP, 3'h0, fsr_pkg::FMT_EXT, '0, {4'hF, 80'h0}, {4'hF, 80'h0});
        reg_rd(fsr_pkg::ADDR_STATE, 16'h0041, 16'hFFFF);
        reg_wr(fsr_pkg::ADDR_CTRL, 16'h003E);
        chk_err(1'b1);
        reg_rd(fsr_pkg::ADDR_STATE, 16'h80C1, 16'hFFFF);
        reg_wr(fsr_pkg::ADDR_STATE, 16'h8088);
        chk_err(1'b0);
        reg_rd(fsr_pkg::ADDR_STATE, 16'h0008, 16'hFFFF);
        reg_wr(fsr_pkg::ADDR_CTRL, 16'h0000);
        chk_err(1'b1);
        reg_wr(fsr_pkg::ADDR_STATE, 16'h0000);
        chk_err(1'b0);
        i_host.issue('{cmd: fsr_pkg::OP_NONE, rel: 3'h0, fmt: fsr_pkg::FMT_EXT, data: '0,
                       cc_we: 1'b1, cc: 4'hA, exc: 6'h20});
        chk_err(1'b1);
        reg_rd(fsr_pkg::ADDR_STATE, 16'hC2A0, 16'hFFFF);
        reg_wr(fsr_pkg::ADDR_STATE, 16'h0000);
        reg_wr(fsr_pkg::ADDR_CTRL, 16'h003F);
        // single in, extended and double out: rebias and integer bit
        e = 8'(1 + ($unsigned($random(seed)) % 254));
        f = 23'($random(seed));
        op(fsr_pkg::OP_PUSH, 3'h0, fsr_pkg::FMT_SGL, {48'h0, 1'b1, e, f}, '0, '0);
        op(fsr_pkg::OP_READ, 3'h0, fsr_pkg::FMT_EXT, '0,
           {4'h8, 1'b1, 15'(e) + 15'd16256, 1'b1, f, 40'h0}, '1);
        op(fsr_pkg::OP_POP, 3'h0, fsr_pkg::FMT_DBL, '0,
           {4'h8, 16'h0, 1'b1, 11'(e) + 11'd896, f, 29'h0}, '1);
        bcd = {$random(seed), $random(seed), 16'($random(seed))};
        op(fsr_pkg::OP_PUSH, 3'h0, fsr_pkg::FMT_BCD, bcd, '0, '0);
        bcd[78:72] = 7'h00;
        op(fsr_pkg::OP_POP, 3'h0, fsr_pkg::FMT_BCD, '0, {4'h8, bcd}, {4'hC, {80{1'b1}}});
        // double written by relative index, read back as single, then freed
        op(fsr_pkg::OP_WRITE, 3'h3, fsr_pkg::FMT_DBL,
           {16'h0, 1'b0, 11'(e) + 11'd896, f, 29'($random(seed))}, '0, '0);
        op(fsr_pkg::OP_READ, 3'h3, fsr_pkg::FMT_SGL, '0,
           {4'h8, 48'h0, 1'b0, e, f}, '1);
        op(fsr_pkg::OP_FREE, 3'h3, fsr_pkg::FMT_EXT, '0, '0, '0);
        reg_rd(fsr_pkg::ADDR_CLASS, 16'hFFFF, 16'hFFFF);
        repeat (3) @(posedge clk_in);
        summarize();
    end
endmodule
